//--- design/slcr_config_readback.v
`timescale 1ns/10ps
`include "slcr_defines.vh"

// Summary of operation
// RL1 - read-only high-density flag: 1 means high-density format, 0 means disabled
// RL2 - read-only five-bit control words per frame count, reported with no offset
// RL3 - each lane checksum is the sum of its link parameters, modulo 256
// RL4 - lanes 0 to 3 have separate checksums; defaults read C3, C4, C5, C6
// RL5 - one read/write power-down bit per physical lane 0 to 7, 1 powers down
// RL6 - reset clears all eight lane power-down bits
// RL7 - checksums follow any change of the parameters that feed them
module slcr_config_readback
(
	input  wire        sys_clk,
	input  wire        reset,
	input  wire [11:0] regAddr,
	input  wire [7:0]  regWriteData,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [7:0]  regReadData,
	input  wire        highDensityFlag,
	input  wire [4:0]  ctrlWordsPerFrame,
	input  wire [7:0]  sharedParamSum,
	output reg  [7:0]  laneForcePowerDown
);

	////////////////////////////////////////////////////////////////////////////////
	// sizes and select codes
	// widths and lane counts are fixed, not meant to be overridden

	localparam SUM_LANES = `SLCR_NUM_SUM_LANES;
	localparam PHY_LANES = `SLCR_NUM_PHY_LANES;
	localparam DATA_W    = `SLCR_DATA_W;

	// select codes of the decoded register set
	localparam [2:0] SEL_NONE     = 3'h0;
	localparam [2:0] SEL_DENSITY  = 3'h1;
	localparam [2:0] SEL_CHECKSUM = 3'h2;
	localparam [2:0] SEL_PWRDN    = 3'h3;

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	// one decode for both paths, so a write and a read never disagree on a register
	function [2:0] regSelect;
		input [11:0] addr;
		begin
			case (addr)
				`SLCR_OFS_DENSITY_CTRL:
				begin
					regSelect = SEL_DENSITY;
				end

				`SLCR_OFS_CHECKSUM0,
				`SLCR_OFS_CHECKSUM1,
				`SLCR_OFS_CHECKSUM2,
				`SLCR_OFS_CHECKSUM3:
				begin
					regSelect = SEL_CHECKSUM;
				end

				`SLCR_OFS_LANE_PWRDN:
				begin
					regSelect = SEL_PWRDN;
				end

				default:
				begin
					regSelect = SEL_NONE;
				end

			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// read word of the density / control word register

	// reserved bits 6:5 always read zero
	function [7:0] densityWord;
		input       hd;
		input [4:0] cf;

		begin
			densityWord = `SLCR_RST_READ;
			densityWord[`SLCR_HD_BIT] = hd; // [RL1]
			densityWord[`SLCR_CF_MSB:`SLCR_CF_LSB] = cf; // [RL2]
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// checksum reset values

	function [7:0] checksumReset;
		input [1:0] idx;

		begin
			case (idx)
				2'h0:
				begin
					checksumReset = `SLCR_RST_CHECKSUM0;
				end

				2'h1:
				begin
					checksumReset = `SLCR_RST_CHECKSUM1;
				end

				2'h2:
				begin
					checksumReset = `SLCR_RST_CHECKSUM2;
				end

				2'h3:
				begin
					checksumReset = `SLCR_RST_CHECKSUM3;
				end

				default:
				begin
					checksumReset = `SLCR_RST_CHECKSUM0;
				end

			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// lane sum

	// the carry out of bit 7 is dropped, which gives the modulo 256 for free
	function [7:0] laneSum;
		input [7:0] common;
		input [7:0] id;

		begin
			laneSum = common + id; // [RL3]
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// per-lane checksums
	// only the lane id differs per lane; the shared parameters come in pre-summed

	wire [7:0]             hdTerm;
	wire [7:0]             cfTerm;
	wire [7:0]             commonSum;
	wire [8*SUM_LANES-1:0] checksumBus;

	assign hdTerm = {7'h00, highDensityFlag};
	assign cfTerm = {3'h0, ctrlWordsPerFrame};
	assign commonSum = sharedParamSum + hdTerm + cfTerm; // [RL3]

	genvar lane;
	generate
		for (lane = 0; lane < SUM_LANES; lane = lane + 1)
		begin : gen_sum
			localparam [7:0] LANE_ID  = lane;
			localparam [1:0] LANE_IDX = lane;

			reg  [7:0] checksum;
			wire [7:0] resetChecksum;
			wire [7:0] next_checksum;

			assign resetChecksum = checksumReset(LANE_IDX); // [RL4]
			assign next_checksum = laneSum(commonSum, LANE_ID); // [RL3]
			assign checksumBus[8*lane +: 8] = checksum;

			// a reset in operation reloads the defaults, the next edge the live sum
			always @(posedge sys_clk)
			begin
				if (reset)
				begin
					checksum <= resetChecksum; // [RL4]
				end
				else
				begin
					// refreshed every cycle, so a read lags a change by one cycle at most
					checksum <= next_checksum; // [RL7]
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// lane power-down control

	wire                 pdWrite;
	wire [PHY_LANES-1:0] next_powerDown;

	// writes to the read-only registers fall through here and change nothing
	assign pdWrite = regWrite && (regSelect(regAddr) == SEL_PWRDN); // [RL5]

	genvar pdLane;
	generate
		for (pdLane = 0; pdLane < PHY_LANES; pdLane = pdLane + 1)
		begin : gen_pd
			wire writeBit;

			assign writeBit = regWriteData[pdLane];
			// bit position equals physical lane number
			assign next_powerDown[pdLane] = pdWrite ? writeBit
				: laneForcePowerDown[pdLane]; // [RL5]
		end
	endgenerate

	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			laneForcePowerDown <= `SLCR_RST_PWRDN; // [RL6]
		end
		else
		begin
			laneForcePowerDown <= next_powerDown; // [RL5]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path: data stand one cycle after the read strobe, then drop to zero

	wire [2:0]        readSel;
	reg  [DATA_W-1:0] selectedChecksum;
	reg  [DATA_W-1:0] next_readData;

	assign readSel = regSelect(regAddr);

	always @*
	begin
		selectedChecksum = checksumBus[7:0];

		case (regAddr[1:0])
			2'h0:
			begin
				selectedChecksum = checksumBus[7:0]; // [RL4]
			end

			2'h1:
			begin
				selectedChecksum = checksumBus[15:8]; // [RL4]
			end

			2'h2:
			begin
				selectedChecksum = checksumBus[23:16]; // [RL4]
			end

			2'h3:
			begin
				selectedChecksum = checksumBus[31:24]; // [RL4]
			end

			default:
			begin
				selectedChecksum = checksumBus[7:0];
			end

		endcase
	end

	always @*
	begin
		next_readData = `SLCR_RST_READ;

		case (readSel)
			SEL_DENSITY:
			begin
				// live inputs, no register between, so no lag on this one
				next_readData = densityWord(highDensityFlag, ctrlWordsPerFrame); // [RL1] [RL2]
			end

			SEL_CHECKSUM:
			begin
				next_readData = selectedChecksum; // [RL4]
			end

			SEL_PWRDN:
			begin
				next_readData = laneForcePowerDown; // [RL5]
			end

			default:
			begin
				// unmapped and reserved addresses read zero
				next_readData = `SLCR_RST_READ;
			end

		endcase
	end

	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			regReadData <= `SLCR_RST_READ;
		end
		else if (regRead)
		begin
			regReadData <= next_readData;
		end
		else
		begin
			// data stand for one cycle only, then the bus reads idle zero
			regReadData <= `SLCR_RST_READ;
		end
	end

endmodule

//--- design/slcr_defines.vh
`ifndef SLCR_DEFINES_VH
`define SLCR_DEFINES_VH

// address and data widths and register offsets on the control port
`define SLCR_ADDR_W            12
`define SLCR_DATA_W            8
`define SLCR_OFS_DENSITY_CTRL  12'h0592
`define SLCR_OFS_CHECKSUM0     12'h05A0
`define SLCR_OFS_CHECKSUM1     12'h05A1
`define SLCR_OFS_CHECKSUM2     12'h05A2
`define SLCR_OFS_CHECKSUM3     12'h05A3
`define SLCR_OFS_LANE_PWRDN    12'h05B0

// field positions in the density / control word register
`define SLCR_HD_BIT            7
`define SLCR_CF_MSB            4
`define SLCR_CF_LSB            0

// lane counts
`define SLCR_NUM_SUM_LANES     4
`define SLCR_NUM_PHY_LANES     8

// reset values
`define SLCR_RST_CHECKSUM0     8'hC3
`define SLCR_RST_CHECKSUM1     8'hC4
`define SLCR_RST_CHECKSUM2     8'hC5
`define SLCR_RST_CHECKSUM3     8'hC6
`define SLCR_RST_PWRDN         8'h00
`define SLCR_RST_READ          8'h00

`endif

//--- tb/serial_link_config_readback_tb.sv
`timescale 1ns/10ps
module serial_link_config_readback_tb;
	reg         sys_clk           = 1'h0;
	reg         reset             = 1'h1;
	reg         regWrite          = 1'h0;
	reg         regRead           = 1'h0;
	reg         highDensityFlag   = 1'h0;
	reg  [11:0] regAddr           = 12'h000;
	reg  [7:0]  regWriteData      = 8'h00;
	reg  [7:0]  sharedParamSum    = 8'hC3;
	reg  [4:0]  ctrlWordsPerFrame = 5'h00;
	wire [7:0]  regReadData;
	wire [7:0]  laneForcePowerDown;
	wire [7:0]  laneLive;
	integer     mismatches        = 0;
	integer     tests_run         = 0;

	always #2 sys_clk = ~sys_clk;

	slcr_config_readback u_slcr_config_readback
	(
		.sys_clk            (sys_clk),
		.reset              (reset),
		.regAddr            (regAddr),
		.regWriteData       (regWriteData),
		.regWrite           (regWrite),
		.regRead            (regRead),
		.regReadData        (regReadData),
		.highDensityFlag    (highDensityFlag),
		.ctrlWordsPerFrame  (ctrlWordsPerFrame),
		.sharedParamSum     (sharedParamSum),
		.laneForcePowerDown (laneForcePowerDown)
	);

	slcr_rx_model u_slcr_rx_model
	(
		.laneForcePowerDown (laneForcePowerDown),
		.laneLive           (laneLive)
	);

	task chk(input [7:0] g, input [7:0] e);
	begin
		tests_run = tests_run + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t: got %h, expected %h", $time, g, e);
		end
	end
	endtask

	// strobe one cycle, then look at the data in the one cycle they stand
	task rd(input [11:0] a, input [7:0] e);
	begin
		@(posedge sys_clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'h0;
		#1;
		chk(regReadData, e);
	end
	endtask

	task wr(input [11:0] a, input [7:0] d);
	begin
		@(posedge sys_clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge sys_clk);
		regWrite <= 1'h0;
	end
	endtask

	task set_params(input hd, input [4:0] cf, input [7:0] sum);
	begin
		@(posedge sys_clk);
		highDensityFlag <= hd;
		ctrlWordsPerFrame <= cf;
		sharedParamSum <= sum;
	end
	endtask

	task test_defaults;
		integer k;
	begin
		for (k = 0; k < 4; k = k + 1)
		begin
			rd(12'h05A0 + k, 8'hC3 + k);
		end
		rd(12'h05B0, 8'h00);
		rd(12'h0592, 8'h00);
		$display("test defaults done");
	end
	endtask

	task test_params;
		integer k;
	begin
		set_params(1'h1, 5'h1F, 8'hFF);
		rd(12'h0592, 8'h9F);
		for (k = 0; k < 4; k = k + 1)
		begin
			rd(12'h05A0 + k, 8'h1F + k);
		end
		set_params(1'h0, 5'h05, 8'h10);
		rd(12'h0592, 8'h05);
		for (k = 0; k < 4; k = k + 1)
		begin
			rd(12'h05A0 + k, 8'h15 + k);
		end
		$display("test params done");
	end
	endtask

	task test_powerdown;
	begin
		wr(12'h05B0, 8'hA5);
		wr(12'h05A0, 8'hFF);
		rd(12'h05B0, 8'hA5);
		chk(laneLive, 8'h5A);
		rd(12'h05A0, 8'h15);
		rd(12'h07FF, 8'h00);
		wr(12'h05B0, 8'h5A);
		rd(12'h05B0, 8'h5A);
		chk(laneLive, 8'hA5);
		$display("test powerdown done");
	end
	endtask

	task test_reset;
		integer k;
	begin
		@(posedge sys_clk);
		reset <= 1'h1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		rd(12'h05B0, 8'h00);
		chk(laneLive, 8'hFF);
		for (k = 0; k < 4; k = k + 1)
		begin
			rd(12'h05A0 + k, 8'h15 + k);
		end
		$display("test reset done");
	end
	endtask

	task complete_run;
	begin
		$display("counts: %0d comparisons, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
		begin
			$display("verification passed");
		end
		else
		begin
			$display("verification failed");
		end
		$finish;
	end
	endtask

	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'h0;
		test_defaults;
		test_params;
		test_powerdown;
		test_reset;
		complete_run;
	end
endmodule

//--- tb/slcr_chk_assertions.sv
`timescale 1ns/10ps
module slcr_chk
(
	input wire        sys_clk,
	input wire        reset,
	input wire [11:0] regAddr,
	input wire [7:0]  regWriteData,
	input wire        regWrite,
	input wire        regRead,
	input wire [7:0]  regReadData,
	input wire        highDensityFlag,
	input wire [4:0]  ctrlWordsPerFrame,
	input wire [7:0]  sharedParamSum,
	input wire [7:0]  laneForcePowerDown
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_wr;
		regWrite && regAddr == 12'h05B0 |=> laneForcePowerDown == $past(regWriteData);
	endproperty
	a_wr: assert property (p_wr) else $error("pd write");

	property p_pdhold;
		!(regWrite && regAddr == 12'h05B0) |=> $stable(laneForcePowerDown);
	endproperty
	a_pdhold: assert property (p_pdhold) else $error("pd changed without write");

	property p_pdread;
		regRead && regAddr == 12'h05B0 |=> regReadData == $past(laneForcePowerDown);
	endproperty
	a_pdread: assert property (p_pdread) else $error("pd readback");

	property p_rst;
		disable iff (1'b0) reset |=> laneForcePowerDown == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("pd reset");

	property p_hd;
		regRead && regAddr == 12'h0592
			|=> regReadData == {$past(highDensityFlag), 2'b00, $past(ctrlWordsPerFrame)};
	endproperty
	a_hd: assert property (p_hd) else $error("hd cf");

	// inputs held a cycle so the registered sum has caught up
	property p_cs;
		regRead && regAddr[11:2] == 10'h168 && !$past(reset) && $stable(sharedParamSum)
			&& $stable(highDensityFlag) && $stable(ctrlWordsPerFrame)
			|=> regReadData == $past(sharedParamSum) + $past(highDensityFlag)
			+ $past(ctrlWordsPerFrame) + $past(regAddr[1:0]);
	endproperty
	a_cs: assert property (p_cs) else $error("checksum");
endmodule
bind slcr_config_readback slcr_chk u_slcr_chk(.*);

//--- tb/slcr_rx_model.sv
`timescale 1ns/10ps
// far-end receiver: a lane forced down carries nothing
module slcr_rx_model(
	input wire [7:0] laneForcePowerDown,
	output wire [7:0] laneLive
);
	assign laneLive = ~laneForcePowerDown;
endmodule
